// ---- logic/erase_timer.v ----
`timescale 1ns/100ps
// Counts the erase duration from a start pulse
module erase_timer #(
  parameter CYCLES = 200000
) (
  // Clock and reset
  input wire mclk_i,
  input wire rst_i,
  // Control
  input wire start_i,
  output wire busy_o,
  output reg done_o
);
  reg [31:0] count;
  reg run;

  assign busy_o = run;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      count <= 32'h0000_0000;
      run <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !run) begin
        run <= 1'b1;
        count <= CYCLES - 1;
      end else if (run) begin
        if (count == 32'h0000_0000) begin
          run <= 1'b0;
          done_o <= 1'b1;
        end else begin
          count <= count - 32'h0000_0001;
        end
      end
    end
  end
endmodule

// ---- logic/flash_ctl_map.vh ----
// Operation
// R1: Operation control register writes accepted only while user program mode is active.
// R2: Writing 1 to start bit begins erase or hard lock operation.
// R3: Erase start halts the CPU for the erase time, then resumes it.
// R4: Byte reads and byte programs proceed without touching the start bit.
// R5: Unlock key register clears to zero on reset; mode disabled.
// R6: User program mode enabled only while key equals 10100101B.
// R7: Sector address built from low and high byte registers.
// R8: Sectors are 128 bytes; low byte bits 6 to 0 ignored.
// R9: Software loads the sector base before programming in a new sector.
// R10: Erase unit is one sector; erase before programming a byte.
// R11: 496 or 504 erasable sectors, per memory size option.
// R12: Erase completes no sooner than 4 ms after start.
// R13: No sector erase in tool mode; only user program mode.
// R14: Software erase sequence: key, sector, 10100001B, then key zero.
// R15: Software sets key just before erase and raises start bit.
// R16: Valid erase erases sector and clears start bit automatically.
// R17: Erase start with mode disabled does nothing; start bit stays 1.
// R18: Upper nibble 0110 sets hard lock, blocking writes and erases.
// R19: Operation 0101000x makes an unlocked store a one-byte program.
// R20: Protected boot area refuses erase and program but allows reads.
// R21: Unknown operation encodings ignore stores and erase starts.
// R22: Reads of operation control register return the start bit.
`ifndef FLASH_CTL_MAP_VH
`define FLASH_CTL_MAP_VH
`define OFS_OPERATION_CONTROL 12'h000
`define OFS_WRITE_UNLOCK_KEY 12'h004
`define OFS_SECTOR_ADDRESS_LOW 12'h008
`define OFS_SECTOR_ADDRESS_HIGH 12'h00C
`define OFS_CONFIG 12'h010
`define OFS_STATUS 12'h014
`define UNLOCK_KEY_VALUE 8'hA5
`define KEY_RESET 8'h00
`define OP_RESET 8'h00
`define SEC_RESET 8'h00
`define CFG_RESET 8'h00
`define OP_ERASE 4'hA
`define OP_PROGRAM 4'h5
`define OP_HARD_LOCK 4'h6
`define OP_PROG_MID 3'h0
`define START_BIT 0
`define SECTOR_LOW_BIT 7
`define CFG_SIZE_62K 0
`define CFG_BOOT_PROT 1
`define CFG_BOOT_SIZE_LSB 2
`define ERASE_TIME_US 10000
`define CLK_MHZ 20
`define SECTORS_63K 9'd504
`define SECTORS_62K 9'd496
`endif

// ---- logic/flash_user_program_control.v ----
// Chosen here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "flash_ctl_map.vh"
module flash_user_program_control #(
  parameter ERASE_CYCLES = `ERASE_TIME_US * `CLK_MHZ
) (
  // Clock and reset
  input wire mclk_i,
  input wire rst_i,
  // AHB-Lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  // CPU program-memory access
  input wire mem_store_i,
  input wire mem_load_i,
  input wire [15:0] mem_addr_i,
  input wire tool_mode_i,
  input wire chip_erase_i,
  output wire cpu_halt_o,
  // Flash array strobes
  output reg erase_req_o,
  output reg [15:0] erase_base_o,
  output reg prog_req_o,
  output reg [15:0] prog_addr_o,
  output wire read_en_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] op_ctl;
  reg [7:0] key;
  reg [7:0] sec_low;
  reg [7:0] sec_high;
  reg [7:0] cfg;
  reg hard_locked;
  reg erase_refused;
  reg wr_pend;
  reg [11:0] wr_addr;
  wire user_mode;
  wire timer_busy;
  wire timer_done;
  wire [15:0] sector_base;
  wire [8:0] sector_num;
  wire [15:0] boot_top;
  wire is_erase;
  wire is_prog;
  wire is_lock;
  wire start_wr;
  wire start_now;
  wire [8:0] sector_limit;
  wire [31:0] status_word;
  wire ctl_wr;

  function in_boot;
    input [15:0] a;
    input [15:0] top;
    begin
      in_boot = (a >= 16'h0100) && (a < top);
    end
  endfunction

  assign user_mode = (key == `UNLOCK_KEY_VALUE) && !tool_mode_i; // [R6] [R13]
  assign sector_base = {sec_high, sec_low[`SECTOR_LOW_BIT], 7'h00}; // [R7] [R8]
  assign sector_num = sector_base[15:7];
  assign sector_limit = cfg[`CFG_SIZE_62K] ? `SECTORS_62K : `SECTORS_63K; // [R11]
  assign boot_top = 16'h0200 << cfg[`CFG_BOOT_SIZE_LSB+1:`CFG_BOOT_SIZE_LSB];
  assign is_erase = op_ctl[7:4] == `OP_ERASE; // [R1]
  assign is_lock = op_ctl[7:4] == `OP_HARD_LOCK; // [R18]
  assign is_prog = (op_ctl[7:4] == `OP_PROGRAM) && (op_ctl[3:1] == `OP_PROG_MID); // [R19]
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign cpu_halt_o = timer_busy; // [R3]
  assign read_en_o = mem_load_i; // [R4] [R20]

  // ----------------------------------------
  // Bus address phase capture
  // ----------------------------------------
  always @(posedge mclk_i) begin
    if (rst_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end else if (hready_i) begin
      wr_pend <= hsel_i && htrans_i[1] && hwrite_i;
      wr_addr <= haddr_i[11:0];
    end
  end

  assign ctl_wr = wr_pend && (wr_addr == `OFS_OPERATION_CONTROL) && user_mode; // [R1]
  assign start_wr = ctl_wr && hwdata_i[`START_BIT] && !op_ctl[`START_BIT]; // [R2] [R15]
  assign start_now = start_wr && (hwdata_i[7:4] == `OP_ERASE) && !hard_locked
    && !timer_busy && !in_boot(sector_base, boot_top) && (sector_num < sector_limit); // [R10] [R20] [R21]
  assign status_word = {29'h0000_0000, erase_refused, hard_locked, timer_busy};

  // ----------------------------------------
  // Register writes and operations
  // ----------------------------------------
  always @(posedge mclk_i) begin
    if (rst_i) begin
      op_ctl <= `OP_RESET;
      key <= `KEY_RESET; // [R5]
      sec_low <= `SEC_RESET;
      sec_high <= `SEC_RESET;
      cfg <= `CFG_RESET;
      hard_locked <= 1'b0;
      erase_refused <= 1'b0;
      erase_req_o <= 1'b0;
      erase_base_o <= 16'h0000;
    end else begin
      erase_req_o <= 1'b0;
      if (chip_erase_i && tool_mode_i)
        hard_locked <= 1'b0; // [R18]
      if (wr_pend) begin
        case (wr_addr)
          `OFS_WRITE_UNLOCK_KEY: key <= hwdata_i[7:0];
          `OFS_SECTOR_ADDRESS_LOW: sec_low <= hwdata_i[7:0];
          `OFS_SECTOR_ADDRESS_HIGH: sec_high <= hwdata_i[7:0];
          `OFS_CONFIG: cfg <= hwdata_i[7:0];
          default: ;
        endcase
      end
      if (ctl_wr) begin
        op_ctl <= hwdata_i[7:0];
        if (hwdata_i[7:4] == `OP_HARD_LOCK && hwdata_i[`START_BIT]) begin
          hard_locked <= 1'b1; // [R18]
          op_ctl[`START_BIT] <= 1'b0;
        end
      end
      if (start_now) begin
        erase_req_o <= 1'b1;
        erase_base_o <= sector_base;
        erase_refused <= 1'b0;
      end else if (start_wr && hwdata_i[7:4] == `OP_ERASE) begin
        erase_refused <= 1'b1;
      end
      // Erase start while locked out of user mode only sets the start bit and starts no erase
      if (wr_pend && wr_addr == `OFS_OPERATION_CONTROL && !user_mode && hwdata_i[`START_BIT])
        op_ctl[`START_BIT] <= 1'b1; // [R17]
      if (timer_done)
        op_ctl[`START_BIT] <= 1'b0; // [R16]
    end
  end

  erase_timer #(
    .CYCLES(ERASE_CYCLES)
  ) u_erase_timer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(start_now), // [R3] [R12]
    .busy_o(timer_busy),
    .done_o(timer_done)
  );

  // ----------------------------------------
  // Byte programming
  // ----------------------------------------
  always @(posedge mclk_i) begin
    if (rst_i) begin
      prog_req_o <= 1'b0;
      prog_addr_o <= 16'h0000;
    end else begin
      prog_req_o <= 1'b0;
      if (mem_store_i && user_mode && is_prog && !hard_locked && !timer_busy
          && mem_addr_i[15:7] == sector_num && !in_boot(mem_addr_i, boot_top)) begin // [R4] [R19] [R20]
        prog_req_o <= 1'b1;
        prog_addr_o <= mem_addr_i;
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @(posedge mclk_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
      case (haddr_i[11:0])
        `OFS_OPERATION_CONTROL: hrdata_o <= {24'h00_0000, op_ctl}; // [R22]
        `OFS_WRITE_UNLOCK_KEY: hrdata_o <= {24'h00_0000, key};
        `OFS_SECTOR_ADDRESS_LOW: hrdata_o <= {24'h00_0000, sec_low};
        `OFS_SECTOR_ADDRESS_HIGH: hrdata_o <= {24'h00_0000, sec_high};
        `OFS_CONFIG: hrdata_o <= {24'h00_0000, cfg};
        `OFS_STATUS: hrdata_o <= status_word;
        default: hrdata_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ---- test/flash_user_program_control_monitor.sv ----
`timescale 1ns/100ps
module flash_user_program_control_monitor #(
  parameter ERASE_CYCLES = 20
) (
  // Clock and reset
  input wire mclk_i,
  input wire rst_i,
  // Watched ports
  input wire mem_store_i,
  input wire mem_load_i,
  input wire [15:0] mem_addr_i,
  input wire tool_mode_i,
  input wire cpu_halt_o,
  input wire erase_req_o,
  input wire [15:0] erase_base_o,
  input wire prog_req_o,
  input wire [15:0] prog_addr_o,
  input wire read_en_o
);
  // ----
  // Assertions
  // ----
  logic [31:0] halt_cnt;
  always @(posedge mclk_i) halt_cnt <= (rst_i || !cpu_halt_o) ? 32'h0000_0000 : halt_cnt + 32'h0000_0001;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence halt_run;
    cpu_halt_o [*8];
  endsequence
  chk_load_read: assert property (read_en_o == mem_load_i) else $error("read enable off");
  chk_erase_pulse: assert property (erase_req_o |=> !erase_req_o) else $error("long erase pulse");
  chk_sector_base: assert property (erase_req_o |-> erase_base_o[6:0] == 7'h00) else $error("bad base");
  chk_erase_halt: assert property (erase_req_o |-> ##[0:2] halt_run) else $error("no cpu halt");
  chk_halt_len: assert property ($fell(cpu_halt_o) |->
    halt_cnt >= ERASE_CYCLES - 1 && halt_cnt <= ERASE_CYCLES + 1) else $error("halt length wrong");
  chk_no_tool: assert property (erase_req_o |-> !$past(tool_mode_i)) else $error("erase in tool mode");
  chk_prog_cause: assert property (prog_req_o |->
    $past(mem_store_i) && prog_addr_o == $past(mem_addr_i)) else $error("program without store");
  chk_prog_pulse: assert property (prog_req_o |=> !prog_req_o) else $error("long program pulse");
  chk_erase_idle: assert property (erase_req_o |-> !$past(cpu_halt_o)) else $error("erase while busy");
endmodule
bind flash_user_program_control flash_user_program_control_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) u_mon (
  .mclk_i(mclk_i), .rst_i(rst_i), .mem_store_i(mem_store_i), .mem_load_i(mem_load_i), .mem_addr_i(mem_addr_i),
  .tool_mode_i(tool_mode_i), .cpu_halt_o(cpu_halt_o), .erase_req_o(erase_req_o), .erase_base_o(erase_base_o),
  .prog_req_o(prog_req_o), .prog_addr_o(prog_addr_o), .read_en_o(read_en_o));

// ---- test/flash_user_program_control_tb.sv ----
`timescale 1ns/100ps
`include "flash_ctl_map.vh"
module flash_user_program_control_tb;
  localparam [11:0] OP = `OFS_OPERATION_CONTROL, KEY = `OFS_WRITE_UNLOCK_KEY;
  reg mclk_i = 0, rst_i = 1, hwrite_i = 0, mem_store_i = 0, mem_load_i = 0, tool_mode_i = 0, chip_erase_i = 0;
  reg [31:0] haddr_i = 0, hwdata_i = 0, r;
  reg [1:0] htrans_i = 0;
  reg [15:0] mem_addr_i = 0, m, pa;
  reg [7:0] hi, lo;
  reg rd_ph = 0;
  wire [31:0] hrdata_o;
  wire [15:0] erase_base_o, prog_addr_o;
  wire hreadyout_o, hresp_o, cpu_halt_o, erase_req_o, prog_req_o, read_en_o;
  integer seed = 32'h0000_6c34, errors = 0, total_checks = 0, cyc = 0, n;
  logic [15:0] rd_q[$];
  logic [16:0] ev_q[$];
  flash_user_program_control #(.ERASE_CYCLES(20)) DUT (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(1'b1),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .mem_store_i(mem_store_i), .mem_load_i(mem_load_i), .mem_addr_i(mem_addr_i), .tool_mode_i(tool_mode_i),
    .chip_erase_i(chip_erase_i), .cpu_halt_o(cpu_halt_o), .erase_req_o(erase_req_o), .erase_base_o(erase_base_o),
    .prog_req_o(prog_req_o), .prog_addr_o(prog_addr_o), .read_en_o(read_en_o));
  initial forever #25 mclk_i = ~mclk_i;
  task check(input string nm, input logic [16:0] exp, input logic [16:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tally_and_finish;
    check("pending events", 17'h0_0000, 17'(ev_q.size()));
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    r = $random(seed);
    htrans_i <= 2'h2;
    haddr_i <= {20'h0_0000, a};
    hwrite_i <= w;
    do @(posedge mclk_i); while (!hreadyout_o);
    htrans_i <= 2'h0;
    hwdata_i <= {r[31:8], d};
    rd_ph <= !w;
    do @(posedge mclk_i); while (!hreadyout_o);
    rd_ph <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [15:0] me);
    rd_q.push_back(me);
    bus(1'b0, a, 8'h00);
  endtask
  task store(input logic [15:0] a);
    mem_addr_i <= a;
    mem_store_i <= 1'b1;
    @(posedge mclk_i);
    mem_store_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    mem_load_i <= ~mem_load_i;
    if (cyc == 5000) begin
      errors++;
      tally_and_finish;
    end
    if (rd_ph) begin
      m = rd_q.pop_front();
      check("register read", {9'h000, m[7:0]}, {9'h000, hrdata_o[7:0] & m[15:8]});
    end
    if (erase_req_o) check("erase base", ev_q.pop_front(), {1'b1, erase_base_o});
    if (prog_req_o) check("program address", ev_q.pop_front(), {1'b0, prog_addr_o});
  end
  // ----
  // Stimulus
  // ----
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rd(KEY, 16'hff00);
    rd(OP, 16'h0100);
    for (int i = 0; i < 2; i++) begin
      r = $random(seed);
      hi = 8'h02 + r[7:0] % 8'hf8;
      lo = r[15:8];
      ev_q.push_back({1'b1, hi, lo & 8'h80});
      bus(1'b1, KEY, 8'ha5);
      bus(1'b1, `OFS_SECTOR_ADDRESS_HIGH, hi);
      bus(1'b1, `OFS_SECTOR_ADDRESS_LOW, lo);
      bus(1'b1, OP, 8'ha1);
      for (n = 0; n < 200 && (n < 3 || cpu_halt_o); n++) @(posedge mclk_i);
      bus(1'b1, KEY, 8'h00);
      rd(OP, 16'h0100);
    end
    pa = {hi, lo[7], r[22:16]};
    bus(1'b1, KEY, 8'ha5);
    bus(1'b1, OP, 8'h51);
    ev_q.push_back({1'b0, pa});
    store(pa);
    bus(1'b1, OP, 8'h30);
    store(pa);
    bus(1'b1, OP, 8'h50);
    bus(1'b1, KEY, 8'ha4);
    store(pa);
    bus(1'b1, KEY, 8'ha5);
    tool_mode_i <= 1'b1;
    bus(1'b1, OP, 8'ha1);
    store(pa);
    tool_mode_i <= 1'b0;
    bus(1'b1, OP, 8'h61);
    bus(1'b1, OP, 8'h50);
    store(pa);
    tool_mode_i <= 1'b1;
    chip_erase_i <= 1'b1;
    @(posedge mclk_i);
    chip_erase_i <= 1'b0;
    tool_mode_i <= 1'b0;
    bus(1'b1, OP, 8'h50);
    ev_q.push_back({1'b0, pa});
    store(pa);
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    bus(1'b1, OP, 8'ha1);
    repeat (30) @(posedge mclk_i);
    rd(OP, 16'h0101);
    bus(1'b1, KEY, 8'ha5);
    bus(1'b1, OP, 8'h00);
    bus(1'b1, `OFS_SECTOR_ADDRESS_HIGH, 8'h01);
    bus(1'b1, `OFS_SECTOR_ADDRESS_LOW, 8'h00);
    bus(1'b1, OP, 8'ha1);
    repeat (5) @(posedge mclk_i);
    rd(`OFS_STATUS, 16'h0404);
    rd(OP, 16'h0101);
    tally_and_finish;
  end
endmodule
